// ===== bench/icc_checker.sv
// Purpose: port-level checks of the input capture control block
// Assumes: axi4-lite slave on aclk, synchronous active-low reset
// Notes:   bound to icc_top below
`timescale 1ns/1ps
`include "icc_defs.svh"
module icc_checker (
  // clock and reset
  input wire logic        aclk,
  input wire logic        aresetn,
  // write channels
  input wire logic        awvalid,
  input wire logic        awready,
  input wire logic        wvalid,
  input wire logic        wready,
  input wire logic        bvalid,
  input wire logic        bready,
  // read channels
  input wire logic        arvalid,
  input wire logic        arready,
  input wire logic [11:0] araddr,
  input wire logic        rvalid,
  input wire logic        rready,
  input wire logic [31:0] rdata,
  // interrupt
  input wire logic        irq
);
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  wire ar_go = arvalid && arready;

  a_write_answer: assert property (awvalid && awready && wvalid && wready |=> bvalid)
    else $error("write not answered next cycle");
  a_resp_holds: assert property (bvalid && !bready |=> bvalid)
    else $error("write response dropped early");
  a_read_holds: assert property (rvalid && !rready |=> rvalid && $stable(rdata))
    else $error("read data not held");
  a_read_refused: assert property (rvalid |-> !arready)
    else $error("read address taken while data pending");
  a_ctl0_layout: assert property (ar_go && araddr[11:2] == `ICC_IDX_CTL0 |=> (rdata & ~32'h77) == 0)
    else $error("unused control bits read nonzero");
  a_ctl1_layout: assert property (ar_go && araddr[11:2] == `ICC_IDX_CTL1 |=> (rdata & ~32'h3f) == 0)
    else $error("unused edge select bits read nonzero");
  a_ctl2_layout: assert property (ar_go && araddr[11:2] == `ICC_IDX_CTL2 |=> (rdata & ~32'h70) == 0)
    else $error("unused filter bits read nonzero");

  c_write: cover property (bvalid && bready);
  c_read: cover property (rvalid && rready);
  c_irq: cover property ($rose(irq));
endmodule
bind icc_top icc_checker icc_checker_i (.aclk, .aresetn, .awvalid, .awready, .wvalid, .wready, .bvalid, .bready,
  .arvalid, .arready, .araddr, .rvalid, .rready, .rdata, .irq);

// ===== bench/icc_pins.sv
// Purpose: external signal sources on the three capture pins
// Assumes: push-pull drivers, so a level holds between changes
// Notes:   changes land just after a rising edge
`timescale 1ns/1ps
module icc_pins (
  // clock
  input wire logic aclk,
  // capture pins
  output logic [2:0] cap_in
);
  initial cap_in = 3'h0;
  task automatic set_pin(input int ch, input logic v);
    @(posedge aclk);
    cap_in[ch] <= v;
  endtask
endmodule

// ===== bench/icc_top_test.sv
// Purpose: self-checking bench of the input capture control block
// Assumes: pin to flag latency at most eleven cycles with the filter on
// Notes:   registers reached through axi4-lite tasks
`timescale 1ns/1ps
`include "icc_defs.svh"
module icc_top_test;
  logic        aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
  logic        awready, wready, bvalid, arready, rvalid, irq;
  logic [11:0] awaddr, araddr;
  logic [31:0] wdata, rdata;
  logic [1:0]  bresp, rresp;
  logic [2:0]  cap_in;
  int          n_errors, checks;
  localparam logic [11:0] A0 = {`ICC_IDX_CTL0, 2'h0};
  localparam logic [11:0] A1 = {`ICC_IDX_CTL1, 2'h0};
  localparam logic [11:0] A2 = {`ICC_IDX_CTL2, 2'h0};
  localparam logic [11:0] AS = {`ICC_IDX_STAT, 2'h0};
  localparam logic [11:0] AM = {`ICC_IDX_MASK, 2'h0};
  localparam logic [1:0]  OK = `ICC_RESP_OKAY;
  localparam logic [1:0]  ER = `ICC_RESP_SLVERR;

  icc_top icc_top_i (.aclk, .aresetn, .cap_in, .awvalid, .awready, .awaddr, .awprot(3'h0), .wvalid, .wready,
    .wdata, .wstrb(4'h1), .bvalid, .bready, .bresp, .arvalid, .arready, .araddr, .arprot(3'h0), .rvalid,
    .rready, .rdata, .rresp, .irq);
  icc_pins icc_pins_i (.aclk, .cap_in);

  initial begin
    aclk = 1'b0;
    forever #12.5 aclk = ~aclk;
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      n_errors++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic waitc(input int n);
    repeat (n) @(posedge aclk);
  endtask

  task automatic pin(input int ch, input logic v);
    icc_pins_i.set_pin(ch, v);
  endtask

  task automatic wr(input logic [11:0] a, input logic [7:0] d, input logic [1:0] er);
    int         n;
    logic       aw_t;
    logic       w_t;
    logic       b_t;
    logic [1:0] resp;
    n    = 0;
    b_t  = 1'b0;
    resp = 2'h0;
    @(posedge aclk);
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    awaddr  <= a;
    wdata   <= {24'h0, d};
    // readies are sampled settled, before the edge that takes the item, not racing it
    do begin
      @(negedge aclk);
      aw_t = awvalid && awready;
      w_t  = wvalid && wready;
      b_t  = bvalid;
      resp = bresp;
      @(posedge aclk);
      n++;
      if (aw_t) awvalid <= 1'b0;
      if (w_t) wvalid <= 1'b0;
    end while (!b_t && n < 50);
    bready <= 1'b0;
    if (!b_t) n_errors++;
    chk({30'h0, resp}, {30'h0, er});
  endtask

  task automatic rd(input logic [11:0] a, output logic [31:0] d, output logic [1:0] r);
    int   n;
    logic ar_t;
    logic r_t;
    n   = 0;
    r_t = 1'b0;
    d   = 32'h0;
    r   = 2'h0;
    @(posedge aclk);
    arvalid <= 1'b1;
    araddr  <= a;
    rready  <= 1'b1;
    do begin
      @(negedge aclk);
      ar_t = arvalid && arready;
      r_t  = rvalid;
      d    = rdata;
      r    = rresp;
      @(posedge aclk);
      n++;
      if (ar_t) arvalid <= 1'b0;
    end while (!r_t && n < 50);
    rready <= 1'b0;
    if (!r_t) n_errors++;
  endtask

  task automatic rchk(input logic [11:0] a, input logic [31:0] e, input logic [1:0] er);
    logic [31:0] d;
    logic [1:0]  r;
    rd(a, d, r);
    chk(d, e);
    chk({30'h0, r}, {30'h0, er});
  endtask

  task automatic t_regs;
    rchk(A0, 32'h0, OK);
    rchk(A1, 32'h0, OK);
    rchk(A2, 32'h0, OK);
    wr(A0, 8'hff, OK);
    rchk(A0, 32'h77, OK);
    wr(A1, 8'hff, OK);
    rchk(A1, 32'h3f, OK);
    wr(A2, 8'hff, OK);
    rchk(A2, 32'h70, OK);
    wr(A0, 8'h0, OK);
    wr(A1, 8'h0, OK);
    wr(A2, 8'h0, OK);
    wr(12'h100, 8'hff, ER);
    rchk(12'h100, 32'h0, ER);
  endtask

  // code 3 lands on channel 0 again; it must stay silent
  task automatic t_edges;
    int         ch;
    logic [7:0] en, fl;
    for (int c = 0; c < 4; c++) begin
      ch = c % 3;
      en = 8'h10 << ch;
      fl = 8'h01 << ch;
      wr(A1, 8'(c << (2 * ch)), OK);
      waitc(12);
      wr(A0, en, OK);
      pin(ch, 1'b1);
      waitc(12);
      rchk(A0, {24'h0, en | ((c == 1 || c == 2) ? fl : 8'h0)}, OK);
      pin(ch, 1'b0);
      waitc(12);
      rchk(A0, {24'h0, en | ((c != 3) ? fl : 8'h0)}, OK);
      wr(A0, en, OK);
      rchk(A0, {24'h0, en}, OK);
    end
  endtask

  task automatic t_disabled;
    wr(A0, 8'h0, OK);
    wr(A1, 8'h2a, OK);
    for (int ch = 0; ch < 3; ch++) pin(ch, 1'b1);
    waitc(12);
    for (int ch = 0; ch < 3; ch++) pin(ch, 1'b0);
    waitc(12);
    rchk(A0, 32'h0, OK);
  endtask

  task automatic t_filter;
    wr(A2, 8'h20, OK);
    wr(A1, 8'h04, OK);
    waitc(12);
    wr(A0, 8'h20, OK);
    pin(1, 1'b1);
    waitc(2);
    pin(1, 1'b0);
    waitc(12);
    rchk(A0, 32'h20, OK);
    pin(1, 1'b1);
    waitc(12);
    rchk(A0, 32'h22, OK);
    pin(1, 1'b0);
  endtask

  // status holds events from earlier tests, so it is emptied first
  task automatic t_irq;
    logic [31:0] d;
    logic [1:0]  r;
    wr(A0, 8'h10, OK);
    wr(A1, 8'h01, OK);
    wr(A2, 8'h0, OK);
    wr(AM, 8'h0, OK);
    waitc(12);
    rd(AS, d, r);
    pin(0, 1'b1);
    waitc(12);
    chk({31'h0, irq}, 32'h0);
    wr(AM, 8'h01, OK);
    waitc(2);
    chk({31'h0, irq}, 32'h1);
    rchk(AS, 32'h1, OK);
    waitc(2);
    chk({31'h0, irq}, 32'h0);
    pin(0, 1'b0);
  endtask

  task automatic report_and_stop;
    $display("errors=%0d checks=%0d", n_errors, checks);
    if (n_errors == 0 && checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  initial begin
    aresetn  = 1'b0;
    awvalid  = 1'b0;
    wvalid   = 1'b0;
    bready   = 1'b0;
    arvalid  = 1'b0;
    rready   = 1'b0;
    awaddr   = 12'h0;
    araddr   = 12'h0;
    wdata    = 32'h0;
    n_errors = 0;
    checks   = 0;
    repeat (5) @(posedge aclk);
    aresetn <= 1'b1;
    t_regs;
    t_edges;
    t_disabled;
    t_filter;
    t_irq;
    report_and_stop;
  end

  // whole run needs a few hundred cycles
  initial begin
    repeat (20000) @(posedge aclk);
    n_errors++;
    report_and_stop;
  end
endmodule

// ===== rtl/icc_chan.sv
// Purpose: one capture channel: synchroniser, noise filter, edge detector
// Assumes: pin is asynchronous to aclk
// Notes:   event is a one-cycle pulse
`timescale 1ns/1ps
`include "icc_defs.svh"
module icc_chan
  import icc_pkg::*;
(
  // clock and reset
  input  wire logic             aclk,
  input  wire logic             aresetn,
  // pin and configuration
  input  wire logic             pin,
  input  wire icc_chan_cfg_type cfg,
  // event out
  output logic                  event_pulse
);

  icc_chan_state_type s_ff;
  icc_chan_state_type nxt_s;
  logic               rise;
  logic               fall;
  logic               hit;

  always_comb begin
    nxt_s = s_ff;
    // sync1 feeds only sync2
    nxt_s.sync1 = pin;
    nxt_s.sync2 = s_ff.sync1;
    if (!cfg.filt_en) begin
      nxt_s.level = s_ff.sync2;
      nxt_s.cnt   = 3'h0;
    end else if (s_ff.sync2 == s_ff.level) begin
      nxt_s.cnt = 3'h0;
    end else if (s_ff.cnt == `ICC_FILT_CNT - 3'h1) begin
      nxt_s.level = s_ff.sync2;
      nxt_s.cnt   = 3'h0;
    end else begin
      nxt_s.cnt = s_ff.cnt + 3'h1;
    end
    // prev keeps tracking while disabled, so enabling gives no stale edge
    nxt_s.prev = s_ff.level;
    rise = s_ff.level & ~s_ff.prev;
    fall = ~s_ff.level & s_ff.prev;
    case (cfg.edge_sel)
      `ICC_EDGE_FALL: hit = fall;
      `ICC_EDGE_RISE: hit = rise;
      `ICC_EDGE_BOTH: hit = rise | fall;
      default:        hit = 1'b0;
    endcase
    nxt_s.evt = cfg.enable & hit;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_ff <= '0;
    end else begin
      s_ff <= nxt_s;
    end
  end

  assign event_pulse = s_ff.evt;

endmodule

// ===== rtl/icc_defs.svh
// Purpose: constants of the input capture control block
// Assumes: register indices are word indices; byte address is four times the index
// Notes:   included by its bare name
`ifndef ICC_DEFS_SVH
`define ICC_DEFS_SVH

// register word indices
`define ICC_IDX_CTL0       10'h092
`define ICC_IDX_CTL1       10'h093
`define ICC_IDX_CTL2       10'h094
`define ICC_IDX_STAT       10'h095
`define ICC_IDX_MASK       10'h096

// reset values
`define ICC_RST_CTL0       8'h00
`define ICC_RST_CTL1       8'h00
`define ICC_RST_CTL2       8'h00
`define ICC_RST_STAT       3'h0
`define ICC_RST_MASK       3'h0

// implemented bits of each control register
`define ICC_CTL0_MASK      8'h77
`define ICC_CTL1_MASK      8'h3f
`define ICC_CTL2_MASK      8'h70

// field positions
`define ICC_EN_LSB         4
`define ICC_FLAG_LSB       0
`define ICC_ESEL_LSB       0
`define ICC_ESEL_W         2
`define ICC_FILT_LSB       4
`define ICC_NUM_CHAN       3

// edge select codes
`define ICC_EDGE_FALL      2'h0
`define ICC_EDGE_RISE      2'h1
`define ICC_EDGE_BOTH      2'h2

// noise filter: synchronised samples that must differ before the level moves
`define ICC_FILT_CNT       3'h4

// axi responses
`define ICC_RESP_OKAY      2'h0
`define ICC_RESP_SLVERR    2'h2

`endif

// ===== rtl/icc_pkg.sv
// Purpose: types of the input capture control block
// Assumes: constants live in icc_defs.svh
// Notes:   none
package icc_pkg;

  typedef enum logic {wr_collect, wr_resp} icc_wr_state_type;
  typedef enum logic {rd_idle, rd_data} icc_rd_state_type;

  typedef enum logic [2:0] {
    sel_ctl0, sel_ctl1, sel_ctl2, sel_stat, sel_mask, sel_none
  } icc_sel_type;

  typedef struct packed {
    logic       enable;
    logic [1:0] edge_sel;
    logic       filt_en;
  } icc_chan_cfg_type;

  typedef struct packed {
    logic       sync1;
    logic       sync2;
    logic       level;
    logic       prev;
    logic [2:0] cnt;
    logic       evt;
  } icc_chan_state_type;

  typedef struct packed {
    logic [7:0]       ctl0;
    logic [7:0]       ctl1;
    logic [7:0]       ctl2;
    logic [2:0]       stat;
    logic [2:0]       mask;
    icc_wr_state_type wst;
    logic             aw_got;
    logic             w_got;
    logic [11:0]      awaddr;
    logic [7:0]       wdata;
    logic             wstrb0;
    logic [1:0]       bresp;
    icc_rd_state_type rst;
    logic [7:0]       rdata;
    logic [1:0]       rresp;
  } icc_state_type;

endpackage

// ===== rtl/icc_top.sv
// Purpose: input capture control registers and three capture channels behind axi4-lite
// Assumes: capture pins are asynchronous; bus is 32-bit axi4-lite on aclk
// Notes:   only byte lane 0 holds register data; upper bits read as zero
//
// The AXI4-Lite slave port is this design's own decision.
`timescale 1ns/1ps
`include "icc_defs.svh"
module icc_top
  import icc_pkg::*;
(
  // clock and reset
  input  wire logic        aclk,
  input  wire logic        aresetn,
  // capture pins
  input  wire logic [2:0]  cap_in,
  // axi4-lite write address
  input  wire logic        awvalid,
  output logic             awready,
  input  wire logic [11:0] awaddr,
  input  wire logic [2:0]  awprot,
  // axi4-lite write data
  input  wire logic        wvalid,
  output logic             wready,
  input  wire logic [31:0] wdata,
  input  wire logic [3:0]  wstrb,
  // axi4-lite write response
  output logic             bvalid,
  input  wire logic        bready,
  output logic [1:0]       bresp,
  // axi4-lite read address
  input  wire logic        arvalid,
  output logic             arready,
  input  wire logic [11:0] araddr,
  input  wire logic [2:0]  arprot,
  // axi4-lite read data
  output logic             rvalid,
  input  wire logic        rready,
  output logic [31:0]      rdata,
  output logic [1:0]       rresp,
  // interrupt
  output logic             irq
);

  icc_state_type    s_ff;
  icc_state_type    nxt_s;
  icc_chan_cfg_type cfg [`ICC_NUM_CHAN];
  logic [2:0]       ev;
  logic             aw_hs;
  logic             w_hs;
  logic             ar_hs;
  logic             wr_go;
  logic [11:0]      wr_addr;
  logic [7:0]       wr_dat;
  logic             wr_strb;
  icc_sel_type      wsel;
  icc_sel_type      rsel;
  logic [2:0]       stat_clr;

  // word decode shared by both channels of the bus; low address bits ignored
  function automatic icc_sel_type reg_sel(input logic [11:0] addr);
    case (addr[11:2])
      `ICC_IDX_CTL0: reg_sel = sel_ctl0;
      `ICC_IDX_CTL1: reg_sel = sel_ctl1;
      `ICC_IDX_CTL2: reg_sel = sel_ctl2;
      `ICC_IDX_STAT: reg_sel = sel_stat;
      `ICC_IDX_MASK: reg_sel = sel_mask;
      default:       reg_sel = sel_none;
    endcase
  endfunction

  // channels
  genvar gi;
  generate
    for (gi = 0; gi < `ICC_NUM_CHAN; gi++) begin : g_chan
      assign cfg[gi].enable   = s_ff.ctl0[`ICC_EN_LSB + gi];
      assign cfg[gi].edge_sel = s_ff.ctl1[`ICC_ESEL_LSB + `ICC_ESEL_W * gi +: `ICC_ESEL_W];
      assign cfg[gi].filt_en  = s_ff.ctl2[`ICC_FILT_LSB + gi];

      icc_chan u_chan (
        .aclk        (aclk),
        .aresetn     (aresetn),
        .pin         (cap_in[gi]),
        .cfg         (cfg[gi]),
        .event_pulse (ev[gi])
      );
    end
  endgenerate

  // handshake outputs
  assign awready = (s_ff.wst == wr_collect) && !s_ff.aw_got;
  assign wready  = (s_ff.wst == wr_collect) && !s_ff.w_got;
  assign arready = (s_ff.rst == rd_idle);
  assign aw_hs   = awvalid & awready;
  assign w_hs    = wvalid & wready;
  assign ar_hs   = arvalid & arready;

  always_comb begin
    nxt_s    = s_ff;
    stat_clr = 3'h0;

    // write address and data arrive in either order
    if (aw_hs) begin
      nxt_s.aw_got = 1'b1;
      nxt_s.awaddr = awaddr;
    end
    if (w_hs) begin
      nxt_s.w_got  = 1'b1;
      nxt_s.wdata  = wdata[7:0];
      nxt_s.wstrb0 = wstrb[0];
    end
    wr_addr = s_ff.aw_got ? s_ff.awaddr : awaddr;
    wr_dat  = s_ff.w_got ? s_ff.wdata : wdata[7:0];
    wr_strb = s_ff.w_got ? s_ff.wstrb0 : wstrb[0];
    wr_go   = (s_ff.wst == wr_collect) && (s_ff.aw_got | aw_hs) && (s_ff.w_got | w_hs);
    wsel    = reg_sel(wr_addr);
    rsel    = reg_sel(araddr);

    case (s_ff.wst)
      wr_collect: begin
        if (wr_go) begin
          nxt_s.wst    = wr_resp;
          nxt_s.aw_got = 1'b0;
          nxt_s.w_got  = 1'b0;
          nxt_s.bresp  = (wsel == sel_none) ? `ICC_RESP_SLVERR : `ICC_RESP_OKAY;
        end
      end
      wr_resp: begin
        if (bready) begin
          nxt_s.wst = wr_collect;
        end
      end
      default: begin
        nxt_s.wst = wr_collect;
      end
    endcase

    // register writes; a write of 0 to a flag is the only way it clears
    if (wr_go && wr_strb) begin
      case (wsel)
        sel_ctl0: nxt_s.ctl0 = wr_dat & `ICC_CTL0_MASK;
        sel_ctl1: nxt_s.ctl1 = wr_dat & `ICC_CTL1_MASK;
        sel_ctl2: nxt_s.ctl2 = wr_dat & `ICC_CTL2_MASK;
        sel_mask: nxt_s.mask = wr_dat[2:0];
        default:  nxt_s.mask = nxt_s.mask;
      endcase
    end

    // read channel
    case (s_ff.rst)
      rd_idle: begin
        if (ar_hs) begin
          nxt_s.rst   = rd_data;
          nxt_s.rresp = (rsel == sel_none) ? `ICC_RESP_SLVERR : `ICC_RESP_OKAY;
          case (rsel)
            sel_ctl0: nxt_s.rdata = s_ff.ctl0;
            sel_ctl1: nxt_s.rdata = s_ff.ctl1;
            sel_ctl2: nxt_s.rdata = s_ff.ctl2;
            sel_stat: nxt_s.rdata = {5'h00, s_ff.stat};
            sel_mask: nxt_s.rdata = {5'h00, s_ff.mask};
            default:  nxt_s.rdata = 8'h00;
          endcase
          // reading status clears what it returned
          if (rsel == sel_stat) begin
            stat_clr = s_ff.stat;
          end
        end
      end
      rd_data: begin
        if (rready) begin
          nxt_s.rst = rd_idle;
        end
      end
      default: begin
        nxt_s.rst = rd_idle;
      end
    endcase

    // hardware set wins over a software clear in the same cycle
    nxt_s.ctl0[`ICC_FLAG_LSB +: `ICC_NUM_CHAN] = nxt_s.ctl0[`ICC_FLAG_LSB +: `ICC_NUM_CHAN] | ev;
    nxt_s.stat = (s_ff.stat & ~stat_clr) | ev;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_ff      <= '0;
      s_ff.ctl0 <= `ICC_RST_CTL0;
      s_ff.ctl1 <= `ICC_RST_CTL1;
      s_ff.ctl2 <= `ICC_RST_CTL2;
      s_ff.stat <= `ICC_RST_STAT;
      s_ff.mask <= `ICC_RST_MASK;
    end else begin
      s_ff <= nxt_s;
    end
  end

  // outputs
  assign bvalid = (s_ff.wst == wr_resp);
  assign bresp  = s_ff.bresp;
  assign rvalid = (s_ff.rst == rd_data);
  assign rdata  = {24'h000000, s_ff.rdata};
  assign rresp  = s_ff.rresp;
  assign irq    = |(s_ff.stat & s_ff.mask);

endmodule
